// *** core_bus_model.sv ***
`timescale 1ns/1ps

module core_bus_model (
    input wire logic ref_clk,
    input wire logic bus_ack,
    input wire logic [31:0] bus_rdata,
    output logic bus_req,
    output logic bus_write,
    output logic [31:0] bus_addr,
    output logic [31:0] bus_wdata
);
    // ----------------------------------------------------
    // Bus cycle
    // ----------------------------------------------------
    // Released qualifiers carry the inverse of their last value.
    initial begin
        bus_req = 1'b0;
        bus_write = 1'b0;
        bus_addr = 32'h0000_0000;
        bus_wdata = 32'h0000_0000;
    end

    task automatic access(input logic wr, input logic [31:0] addr,
                          input logic [31:0] wdata,
                          output logic [31:0] rdata, output bit ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(posedge ref_clk);
        bus_req <= 1'b1;
        bus_write <= wr;
        bus_addr <= addr;
        bus_wdata <= wdata;
        while (!ok && n < 200) begin
            @(posedge ref_clk);
            n++;
            ok = (bus_ack === 1'b1);
        end
        rdata = bus_rdata;
        bus_req <= 1'b0;
        bus_write <= ~wr;
        bus_addr <= ~addr;
        bus_wdata <= ~wdata;
    endtask
endmodule

// *** divider_core.sv ***
`timescale 1ns/1ps

module divider_core #(
    parameter int WIDTH = 32
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic start,
    input wire logic [WIDTH-1:0] numerator,
    input wire logic [WIDTH-1:0] denominator,
    output logic [WIDTH-1:0] quotient,
    output logic [WIDTH-1:0] remainder,
    output logic busy,
    output logic done
);

    localparam int CW = $clog2(WIDTH);
    localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

    logic [WIDTH-1:0] den;
    logic [CW-1:0] count;
    logic [WIDTH-1:0] next_quotient;
    logic [WIDTH-1:0] next_remainder;
    logic [WIDTH-1:0] next_den;
    logic [CW-1:0] next_count;
    logic next_busy;
    logic next_done;
    logic [WIDTH:0] trial;
    logic [WIDTH:0] diff;

    // ------------------------------------------------------------
    // Restoring division, one quotient bit per cycle.
    // ------------------------------------------------------------
    always_comb begin
        next_quotient = quotient;
        next_remainder = remainder;
        next_den = den;
        next_count = count;
        next_busy = busy;
        next_done = 1'b0;
        trial = {remainder, quotient[WIDTH-1]};
        diff = trial - {1'b0, den};
        if (start) begin
            next_quotient = numerator;
            next_remainder = '0;
            next_den = denominator;
            next_count = '0;
            next_busy = 1'b1;
        end else if (busy) begin
            if (!diff[WIDTH]) begin
                next_remainder = diff[WIDTH-1:0];
                next_quotient = {quotient[WIDTH-2:0], 1'b1};
            end else begin
                next_remainder = trial[WIDTH-1:0];
                next_quotient = {quotient[WIDTH-2:0], 1'b0};
            end
            next_count = count + 1'b1;
            if (count == LAST) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            quotient <= '0;
            remainder <= '0;
            den <= '0;
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            quotient <= next_quotient;
            remainder <= next_remainder;
            den <= next_den;
            count <= next_count;
            busy <= next_busy;
            done <= next_done;
        end
    end

    AST_CORE_DONE_TIME: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        busy && count == LAST && !start |=> done && !busy)
        else $error("Divider core did not finish after the last step.");

endmodule

// *** divider_map.svh ***
`ifndef DIVIDER_MAP_SVH
`define DIVIDER_MAP_SVH

// ----------------------------------------------------------------
// Address region
// ----------------------------------------------------------------
`define DIV_REGION_BASE 32'h4003_0000
`define DIV_REGION_MSB 31
`define DIV_REGION_LSB 10

// ----------------------------------------------------------------
// Register word indexes within the region (byte offset / 4)
// ----------------------------------------------------------------
`define DIV_IDX_DIVIDEND 8'h00
`define DIV_IDX_DIVISOR 8'h01
`define DIV_IDX_QUOTIENT 8'h02
`define DIV_IDX_REMAINDER 8'h03
`define DIV_IDX_CONTROL 8'h04
`define DIV_IDX_STATUS 8'h05

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define DIV_CTRL_SIGNED_BIT 0
`define DIV_STAT_BUSY_BIT 0
`define DIV_STAT_OVERFLOW_BIT 1
`define DIV_DATA_RESET 32'h0000_0000

`endif

// *** divider_pkg.sv ***
package divider_pkg;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_WAIT = 1'b1
    } bus_state_type;

endpackage

// *** integer_divider_unit.sv ***
`timescale 1ns/1ps

// Overview of operation
// - Dividend, divisor, quotient, remainder: 32-bit registers.
// - Control bit selects signed or unsigned division.
// - Each divisor write starts a new division.
// - Finished division loads quotient and remainder.
// - Result or status reads wait until finished.
// - Zero divisor at start sets overflow flag.
// - Registers occupy 1 KB region at 0x40030000.

`include "divider_map.svh"

module integer_divider_unit #(
    parameter int WIDTH = 32
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_ack,
    output logic overflow_flag,
    output logic busy,
    output divider_pkg::bus_state_type bus_state
);
    import divider_pkg::*;

    logic [WIDTH-1:0] dividend;
    logic [WIDTH-1:0] divisor;
    logic [WIDTH-1:0] quotient;
    logic [WIDTH-1:0] remainder;
    logic signed_mode_select;
    logic quot_neg;
    logic rem_neg;
    logic start_div;
    logic [WIDTH-1:0] num_mag;
    logic [WIDTH-1:0] den_mag;
    logic [7:0] held_index;
    logic [WIDTH-1:0] next_dividend;
    logic [WIDTH-1:0] next_divisor;
    logic [WIDTH-1:0] next_quotient;
    logic [WIDTH-1:0] next_remainder;
    logic next_signed_mode_select;
    logic next_quot_neg;
    logic next_rem_neg;
    logic next_start_div;
    logic [WIDTH-1:0] next_num_mag;
    logic [WIDTH-1:0] next_den_mag;
    logic next_overflow_flag;
    logic next_busy;
    logic [31:0] next_bus_rdata;
    logic next_bus_ack;
    bus_state_type next_bus_state;
    logic [7:0] next_held_index;
    logic [WIDTH-1:0] core_quotient;
    logic [WIDTH-1:0] core_remainder;
    logic core_done;
    logic take;
    logic in_region;
    logic [7:0] index;
    logic wr_divisor;
    logic stall_index;
    logic [WIDTH-1:0] final_q;
    logic [WIDTH-1:0] final_r;
    logic [31:0] read_value;
    logic signed_now;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign take = bus_req && !bus_ack && bus_state == BUS_IDLE;
    assign in_region = bus_addr[`DIV_REGION_MSB:`DIV_REGION_LSB] ==
        22'(`DIV_REGION_BASE >> `DIV_REGION_LSB);
    assign index = bus_addr[9:2];
    assign wr_divisor = take && bus_write && in_region &&
        index == `DIV_IDX_DIVISOR;
    assign stall_index = index == `DIV_IDX_QUOTIENT ||
        index == `DIV_IDX_REMAINDER || index == `DIV_IDX_STATUS;
    assign signed_now = signed_mode_select;
    assign final_q = quot_neg ? WIDTH'(0) - core_quotient :
        core_quotient;
    assign final_r = rem_neg ? WIDTH'(0) - core_remainder :
        core_remainder;

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    function automatic logic [31:0] read_mux(input logic [7:0] idx);
        logic [31:0] value;
        value = 32'h0000_0000;
        case (idx)
            `DIV_IDX_DIVIDEND: value = dividend;
            `DIV_IDX_DIVISOR: value = divisor;
            `DIV_IDX_QUOTIENT: value = quotient;
            `DIV_IDX_REMAINDER: value = remainder;
            `DIV_IDX_CONTROL:
                value[`DIV_CTRL_SIGNED_BIT] = signed_mode_select;
            `DIV_IDX_STATUS: begin
                value[`DIV_STAT_BUSY_BIT] = busy;
                value[`DIV_STAT_OVERFLOW_BIT] = overflow_flag;
            end
            default: value = 32'h0000_0000;
        endcase
        return value;
    endfunction

    assign read_value = read_mux(index);

    // ------------------------------------------------------------
    // Register file, start control and bus answer
    // ------------------------------------------------------------
    always_comb begin
        next_dividend = dividend;
        next_divisor = divisor;
        next_quotient = quotient;
        next_remainder = remainder;
        next_signed_mode_select = signed_mode_select;
        next_quot_neg = quot_neg;
        next_rem_neg = rem_neg;
        next_start_div = 1'b0;
        next_num_mag = num_mag;
        next_den_mag = den_mag;
        next_overflow_flag = overflow_flag;
        next_busy = busy;
        next_bus_rdata = bus_rdata;
        next_bus_ack = 1'b0;
        next_bus_state = bus_state;
        next_held_index = held_index;
        if (core_done) begin
            next_quotient = final_q;
            next_remainder = final_r;
            next_busy = 1'b0;
        end
        case (bus_state)
            BUS_IDLE: begin
                if (take) begin
                    next_bus_rdata = 32'h0000_0000;
                    if (!in_region) begin
                        next_bus_ack = 1'b1;
                    end else if (bus_write) begin
                        next_bus_ack = 1'b1;
                        case (index)
                            `DIV_IDX_DIVIDEND: next_dividend = bus_wdata;
                            `DIV_IDX_DIVISOR: begin
                                next_divisor = bus_wdata;
                                next_start_div = 1'b1;
                                next_busy = 1'b1;
                                next_quot_neg = signed_now &&
                                    (dividend[WIDTH-1] ^ bus_wdata[WIDTH-1]);
                                next_rem_neg = signed_now &&
                                    dividend[WIDTH-1];
                                next_num_mag = (signed_now &&
                                    dividend[WIDTH-1]) ?
                                    WIDTH'(0) - dividend : dividend;
                                next_den_mag = (signed_now &&
                                    bus_wdata[WIDTH-1]) ?
                                    WIDTH'(0) - bus_wdata : bus_wdata;
                            end
                            `DIV_IDX_CONTROL: next_signed_mode_select =
                                bus_wdata[`DIV_CTRL_SIGNED_BIT];
                            `DIV_IDX_STATUS: begin
                                if (bus_wdata[`DIV_STAT_OVERFLOW_BIT]) begin
                                    next_overflow_flag = 1'b0;
                                end
                            end
                            default: next_bus_ack = 1'b1;
                        endcase
                    end else if (stall_index && busy) begin
                        next_held_index = index;
                        next_bus_state = BUS_WAIT;
                    end else begin
                        next_bus_rdata = read_value;
                        next_bus_ack = 1'b1;
                    end
                end
            end
            BUS_WAIT: begin
                if (!busy) begin
                    next_bus_rdata = read_mux(held_index);
                    next_bus_ack = 1'b1;
                    next_bus_state = BUS_IDLE;
                end
            end
            default: next_bus_state = BUS_IDLE;
        endcase
        if (wr_divisor && bus_wdata == 32'h0000_0000) begin
            next_overflow_flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dividend <= `DIV_DATA_RESET;
            divisor <= `DIV_DATA_RESET;
            quotient <= `DIV_DATA_RESET;
            remainder <= `DIV_DATA_RESET;
            signed_mode_select <= 1'b0;
            quot_neg <= 1'b0;
            rem_neg <= 1'b0;
            start_div <= 1'b0;
            num_mag <= '0;
            den_mag <= '0;
            overflow_flag <= 1'b0;
            busy <= 1'b0;
            bus_rdata <= 32'h0000_0000;
            bus_ack <= 1'b0;
            bus_state <= BUS_IDLE;
            held_index <= 8'h00;
        end else if (ce) begin
            dividend <= next_dividend;
            divisor <= next_divisor;
            quotient <= next_quotient;
            remainder <= next_remainder;
            signed_mode_select <= next_signed_mode_select;
            quot_neg <= next_quot_neg;
            rem_neg <= next_rem_neg;
            start_div <= next_start_div;
            num_mag <= next_num_mag;
            den_mag <= next_den_mag;
            overflow_flag <= next_overflow_flag;
            busy <= next_busy;
            bus_rdata <= next_bus_rdata;
            bus_ack <= next_bus_ack;
            bus_state <= next_bus_state;
            held_index <= next_held_index;
        end
    end

    // ------------------------------------------------------------
    // Iterative magnitude divider
    // ------------------------------------------------------------
    divider_core #(
        .WIDTH(WIDTH)
    ) u_core (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ce(ce),
        .start(start_div),
        .numerator(num_mag),
        .denominator(den_mag),
        .quotient(core_quotient),
        .remainder(core_remainder),
        .busy(),
        .done(core_done)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_REG_WRITE: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        take && bus_write && in_region && index == `DIV_IDX_DIVIDEND
        |=> dividend == $past(bus_wdata) ##0 bus_ack)
        else $error("Dividend write not stored.");

    AST_UNSIGNED_NO_SIGN: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        wr_divisor && !signed_mode_select |=> !quot_neg && !rem_neg)
        else $error("Unsigned division applied a sign.");

    AST_START: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        wr_divisor |=> start_div && busy ##1 !start_div)
        else $error("Divisor write did not start a division.");

    AST_DONE_LOADS: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        core_done |=> quotient == $past(final_q) &&
            remainder == $past(final_r))
        else $error("Results not loaded at completion.");

    AST_LATENCY: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        wr_divisor ##1 !wr_divisor [*8] |-> ##[1:30] !busy)
        else $error("Division took too long.");

    AST_READ_STALL: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        bus_state == BUS_WAIT && busy |=> !bus_ack)
        else $error("Stalled read answered before completion.");

    AST_OVERFLOW: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        wr_divisor && bus_wdata == 32'h0000_0000 |=> overflow_flag)
        else $error("Zero divisor did not set overflow.");

    AST_REGION: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        take && !in_region |=> bus_ack && bus_rdata == 32'h0000_0000)
        else $error("Access outside region not answered with zero.");

    AST_REM_SIGN: assert property (
        @(posedge ref_clk) disable iff (!reset_n || !ce)
        core_done && rem_neg && core_remainder != '0
        |=> remainder[WIDTH-1])
        else $error("Remainder sign does not follow dividend.");

endmodule

// *** integer_divider_unit_tb_top.sv ***
`timescale 1ns/1ps

`include "divider_map.svh"

module integer_divider_unit_tb_top;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic bus_req, bus_write, bus_ack, overflow_flag, busy;
    logic bus_state;
    logic [31:0] bus_addr, bus_wdata, bus_rdata;
    int num_errors = 0;
    int compares = 0;
    int seed = 32'hC9A7;
    logic [31:0] ta [7] = '{32'hFFFF_FFF9, 32'h0000_0007, 32'hFFFF_FFF9,
        32'h8000_0000, 32'hFFFF_FFFF, 32'h0000_0005, 32'h8000_0000};
    logic [31:0] tb [7] = '{32'h0000_0002, 32'hFFFF_FFFE, 32'hFFFF_FFFE,
        32'hFFFF_FFFF, 32'h0000_0001, 32'h0000_0007, 32'hFFFF_FFFF};
    logic ts [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    always #2 ref_clk = ~ref_clk;

    integer_divider_unit #(.WIDTH(32)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
        .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
        .overflow_flag(overflow_flag), .busy(busy), .bus_state(bus_state)
    );

    core_bus_model master_u (
        .ref_clk(ref_clk), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
        .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata)
    );

    // ----------------------------------------------------
    // Reference model and checks
    // ----------------------------------------------------
    function automatic logic [63:0] model_div(input logic [31:0] a,
                                              input logic [31:0] b,
                                              input logic sgn);
        longint sa, sb;
        sa = sgn ? longint'($signed(a)) : longint'(a);
        sb = sgn ? longint'($signed(b)) : longint'(b);
        if (b == 32'h0000_0000) begin
            return {(sgn && a[31]) ? 32'h0000_0001 : 32'hFFFF_FFFF, a};
        end
        return {32'(sa / sb), 32'(sa % sb)};
    endfunction

    task automatic summarize();
        $display("Comparisons %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp,
                              input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic acc(input logic wr, input logic [31:0] addr,
                       input logic [31:0] wdata, output logic [31:0] d);
        bit ok;
        master_u.access(wr, addr, wdata, d, ok);
        if (!ok) begin
            num_errors++;
            $display("Error bus_ack expected 1 seen timeout");
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        logic [31:0] d;
        acc(1'b1, `DIV_REGION_BASE | {22'h0, idx, 2'b00}, v, d);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        acc(1'b0, `DIV_REGION_BASE | {22'h0, idx, 2'b00}, 32'h0, d);
    endtask

    task automatic run_div(input logic [31:0] a, input logic [31:0] b,
                           input logic sgn, input int first);
        logic [63:0] e;
        logic [31:0] d;
        e = model_div(a, b, sgn);
        wr(`DIV_IDX_DIVIDEND, a);
        wr(`DIV_IDX_CONTROL, {31'h0, sgn});
        wr(`DIV_IDX_DIVISOR, b);
        @(negedge ref_clk);
        check_bit("busy", 1'b1, busy);
        fork
            begin
                repeat (2) @(negedge ref_clk);
                check_bit("bus_state", 1'b1, bus_state);
            end
        join_none
        if (first == 2) begin
            rd(`DIV_IDX_STATUS, d);
            check_bit("status_busy", 1'b0, d[`DIV_STAT_BUSY_BIT]);
        end else if (first == 1) begin
            rd(`DIV_IDX_REMAINDER, d);
            check_word("stalled_remainder", e[31:0], d);
        end
        rd(`DIV_IDX_QUOTIENT, d);
        check_word("quotient", e[63:32], d);
        rd(`DIV_IDX_REMAINDER, d);
        check_word("remainder", e[31:0], d);
    endtask

    // ----------------------------------------------------
    // Watchdog
    // ----------------------------------------------------
    initial begin
        #(4 * 20000);
        num_errors++;
        summarize();
    end

    // ----------------------------------------------------
    // Scenarios
    // ----------------------------------------------------
    initial begin
        logic [31:0] d, a, b;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            rd(8'(k), d);
            check_word("reset_value", 32'h0, d);
        end
        a = $random(seed);
        wr(`DIV_IDX_DIVIDEND, a);
        rd(`DIV_IDX_DIVIDEND, d);
        check_word("dividend", a, d);
        for (int k = 0; k < 7; k++) begin
            run_div(ta[k], tb[k], ts[k], k % 3);
        end
        for (int i = 0; i < 30; i++) begin
            a = $random(seed);
            b = $random(seed);
            if (i % 4 == 0) begin
                b = b & 32'h0000_000F;
            end
            if (b == 32'h0) begin
                b = 32'h0000_0003;
            end
            run_div(a, b, 1'(($random(seed))), i % 3);
        end
        rd(`DIV_IDX_DIVISOR, d);
        check_word("divisor", b, d);
        check_bit("overflow_flag", 1'b0, overflow_flag);
        wr(`DIV_IDX_DIVIDEND, 32'd100);
        wr(`DIV_IDX_CONTROL, 32'h0);
        wr(`DIV_IDX_DIVISOR, 32'd3);
        wr(`DIV_IDX_DIVISOR, 32'd7);
        wr(`DIV_IDX_DIVIDEND, 32'd999);
        rd(`DIV_IDX_QUOTIENT, d);
        check_word("restart_quotient", 32'd14, d);
        rd(`DIV_IDX_REMAINDER, d);
        check_word("restart_remainder", 32'd2, d);
        acc(1'b1, `DIV_REGION_BASE + 32'h400, 32'h1234_5678, d);
        rd(`DIV_IDX_DIVIDEND, d);
        check_word("outside_write", 32'd999, d);
        acc(1'b0, `DIV_REGION_BASE - 32'h4, 32'h0, d);
        check_word("outside_read", 32'h0, d);
        acc(1'b0, `DIV_REGION_BASE + 32'h3FC, 32'h0, d);
        check_word("unmapped_read", 32'h0, d);
        wr(`DIV_IDX_DIVIDEND, 32'd1000);
        wr(`DIV_IDX_DIVISOR, 32'd9);
        repeat (60) begin
            @(posedge ref_clk);
            ce <= 1'($random(seed));
        end
        @(posedge ref_clk);
        ce <= 1'b1;
        rd(`DIV_IDX_QUOTIENT, d);
        check_word("frozen_quotient", 32'd111, d);
        run_div(32'h1234_5678, 32'h0, 1'b0, 0);
        check_bit("overflow_flag", 1'b1, overflow_flag);
        rd(`DIV_IDX_STATUS, d);
        check_bit("status_ovf", 1'b1, d[`DIV_STAT_OVERFLOW_BIT]);
        wr(`DIV_IDX_STATUS, 32'h0000_0002);
        @(negedge ref_clk);
        check_bit("overflow_clear", 1'b0, overflow_flag);
        run_div(32'hF000_0000, 32'h0, 1'b1, 1);
        check_bit("overflow_signed", 1'b1, overflow_flag);
        summarize();
    end
endmodule
